// ### logic/tam_pkg.sv
// Shared constants for the timer A mode-control block
package tam_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_CFG   = 8'h00;
    localparam logic [7:0] A_MODE  = 8'h04;
    localparam logic [7:0] A_CTL   = 8'h0c;
    localparam logic [7:0] A_ILR   = 8'h28;
    localparam logic [7:0] A_MATCH = 8'h30;
    localparam logic [7:0] A_PR    = 8'h38;
    localparam logic [7:0] A_PMR   = 8'h40;
    localparam logic [7:0] A_CNT   = 8'h48;
    localparam logic [7:0] A_FREE  = 8'h50;
    localparam logic [7:0] A_PS    = 8'h5c;
    localparam logic [7:0] A_DMAEV = 8'h6c;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int B_PLO   = 11;
    localparam int B_MRSU  = 10;
    localparam int B_PWMIE = 9;
    localparam int B_ILD   = 8;
    localparam int B_MIE   = 5;
    localparam int B_CDIR  = 4;
    localparam int B_AMS   = 3;
    localparam int B_CMR   = 2;
    localparam int C_RUN   = 0;
    localparam int C_STALL = 1;
    localparam int C_EVT   = 2;
    localparam int C_OTE   = 5;
    localparam int D_MATCH = 1;
    localparam int D_CAP   = 2;
    localparam logic [11:0] MODE_MASK  = 12'hf3f;
    localparam logic [5:0]  CTL_MASK   = 6'h2f;
    localparam logic [2:0]  DMAEV_MASK = 3'h6;
    localparam logic [31:0] MASK16     = 32'h0000ffff;
    localparam logic [31:0] MASK32     = 32'hffffffff;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  TMR_ONESHOT  = 2'h1;
    localparam logic [1:0]  TMR_PERIODIC = 2'h2;
    localparam logic [1:0]  TMR_CAPTURE  = 2'h3;
    localparam logic [2:0]  CFG_32       = 3'h0;
    localparam logic [2:0]  CFG_16       = 3'h4;
    localparam logic [1:0]  EVT_RISE     = 2'h0;
    localparam logic [1:0]  EVT_FALL     = 2'h1;
    localparam logic [1:0]  EVT_BOTH     = 2'h3;
    localparam logic [31:0] RST_WORD     = 32'h00000000;
    localparam int          PR_W         = 8;

endpackage

// ### logic/tam_edge_det.sv
// Rising and falling edge detector for one synchronous level
`timescale 1ns/1ps
module tam_edge_det (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Level in, edges out
    input  wire logic level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic prev;
    } tam_edge_t;

    tam_edge_t st;
    tam_edge_t next_st;

    // Remember last level
    always_comb begin
        next_st      = st;
        next_st.prev = level;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rise = level & ~st.prev;
    assign fall = ~level & st.prev;
endmodule

// ### logic/tam_update_stage.sv
// Shadow stage applying a value next cycle, at time-out or at start
`timescale 1ns/1ps
module tam_update_stage #(
    parameter int W = 40
) (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // Update requests
    input  wire logic         wr,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         defer,
    input  wire logic         timeout,
    input  wire logic         start,
    // Values in force
    output logic [W-1:0]      active,
    output logic [W-1:0]      upcoming,
    output logic              apply
);
    typedef struct packed {
        logic         pend;
        logic [W-1:0] shadow;
        logic [W-1:0] act;
        logic         apply;
    } tam_stage_t;

    tam_stage_t st;
    tam_stage_t next_st;

    if (W < 2) begin : g_bad_width
        $error("tam_update_stage: W must be at least 2");
    end

    // A new write overrides any pending one; time-out commits silently
    // because the counter already reloads from the upcoming value.
    always_comb begin
        next_st       = st;
        next_st.apply = 1'b0;
        if (wr) begin
            next_st.shadow = wr_data;
            if (defer) begin
                next_st.pend = 1'b1;
            end else begin
                next_st.act   = wr_data;
                next_st.pend  = 1'b0;
                next_st.apply = 1'b1;
            end
        end else if (st.pend && timeout) begin
            next_st.act  = st.shadow;
            next_st.pend = 1'b0;
        end else if (st.pend && start) begin
            next_st.act   = st.shadow;
            next_st.pend  = 1'b0;
            next_st.apply = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active   = st.act;
    assign upcoming = st.pend ? st.shadow : st.act;
    assign apply    = st.apply;
endmodule

// ### logic/tam_timer.sv
// Timer A with mode-control register behind an AHB-Lite slave
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
// Function
// - Mode field: 1 one-shot, 2 periodic, 3 capture
// - Mode meaning depends on width configuration (decode here ignores the width)
// - Capture type: 0 edge-count, 1 edge-time
// - Alternate select: 0 capture/compare, 1 PWM
// - Direction bit: 0 down, 1 up from zero
// - PWM always counts down
// - Match enable clear blocks interrupt and DMA
// - Match enable set interrupts on match value
// - Load timing clear: reload next cycle
// - Load timing set: reload at time-out
// - Load timing ignored when counting up
// - Disabled deferred loads apply on enable
// - Match timing: next cycle or time-out
// - Disabled deferred match applies on enable
// - PWM interrupt on selected output edges
// - PWM capture event triggers DMA when enabled
// - Reload drives pin to legacy level
// - Width code 0 is 32-bit, 4 is 16-bit
module tam_timer (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Debug halt request from the core
    input  wire logic        debug_halt,
    // Capture/compare pin
    input  wire logic        ccp_in,
    output logic             ccp_out,
    output logic             ccp_oe,
    // Event pulses
    output logic             match_irq,
    output logic             capture_irq,
    output logic             pwm_irq,
    output logic             timeout_evt,
    output logic             dma_trigger
);
    typedef struct packed {
        logic [2:0]  cfg;
        logic [11:0] mode;
        logic [5:0]  ctl;
        logic [2:0]  dmaev;
        logic [31:0] ilr;
        logic [7:0]  pr;
        logic [31:0] mt;
        logic [7:0]  pmr;
        logic [31:0] cnt;
        logic [7:0]  ps;
        logic [31:0] cap;
        logic        pwm_out;
        logic        run_q;
        logic [7:0]  d_addr;
        logic        d_wr;
        logic        d_rd;
        logic [31:0] rdata;
        logic        match_irq;
        logic        capture_irq;
        logic        pwm_irq;
        logic        timeout;
        logic        dma_trig;
    } tam_state_t;

    tam_state_t st;
    tam_state_t next_st;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic [1:0]  tmr;
    logic        is_pwm;
    logic        is_cap;
    logic        is_tmr;
    logic        w16;
    logic        cfg_ok;
    logic        up;
    logic        active;
    logic [31:0] msk;

    assign tmr    = st.mode[1:0];
    // Alternate select picks PWM over compare; mode 0 stays idle
    assign is_pwm = st.mode[tam_pkg::B_AMS] & ~st.mode[tam_pkg::B_CMR]
                  & (tmr == tam_pkg::TMR_ONESHOT | tmr == tam_pkg::TMR_PERIODIC);
    assign is_cap = ~st.mode[tam_pkg::B_AMS] & (tmr == tam_pkg::TMR_CAPTURE);
    assign is_tmr = ~st.mode[tam_pkg::B_AMS]
                  & (tmr == tam_pkg::TMR_ONESHOT | tmr == tam_pkg::TMR_PERIODIC);
    // Reserved width codes keep the counter frozen
    assign w16    = st.cfg == tam_pkg::CFG_16;
    assign cfg_ok = w16 | (st.cfg == tam_pkg::CFG_32);
    assign msk    = w16 ? tam_pkg::MASK16 : tam_pkg::MASK32;
    assign up     = st.mode[tam_pkg::B_CDIR] & ~is_pwm;
    assign active = st.ctl[tam_pkg::C_RUN] & cfg_ok & (is_pwm | is_tmr | is_cap)
                  & ~(st.ctl[tam_pkg::C_STALL] & debug_halt);

    // ------------------------------------------------------------
    // Edge detection on pin input and PWM output
    // ------------------------------------------------------------
    logic ccp_rise;
    logic ccp_fall;
    logic pwm_rise;
    logic pwm_fall;
    logic [1:0] esel;
    logic ccp_evt;
    logic pwm_evt;

    tam_edge_det u_ccp_edge (
        .hclk    (hclk),
        .hresetn (hresetn),
        .level   (ccp_in),
        .rise    (ccp_rise),
        .fall    (ccp_fall)
    );

    tam_edge_det u_pwm_edge (
        .hclk    (hclk),
        .hresetn (hresetn),
        .level   (st.pwm_out),
        .rise    (pwm_rise),
        .fall    (pwm_fall)
    );

    // Event select code 2 is reserved and yields no events
    assign esel    = st.ctl[tam_pkg::C_EVT+1:tam_pkg::C_EVT];
    assign ccp_evt = (esel == tam_pkg::EVT_RISE & ccp_rise) | (esel == tam_pkg::EVT_FALL & ccp_fall)
                   | (esel == tam_pkg::EVT_BOTH & (ccp_rise | ccp_fall));
    assign pwm_evt = (esel == tam_pkg::EVT_RISE & pwm_rise) | (esel == tam_pkg::EVT_FALL & pwm_fall)
                   | (esel == tam_pkg::EVT_BOTH & (pwm_rise | pwm_fall));

    // ------------------------------------------------------------
    // Load and match update stages
    // ------------------------------------------------------------
    logic        ld_wr;
    logic        mt_wr;
    logic        ld_defer;
    logic        tick;
    logic        hit_to;
    logic        start;
    logic [39:0] ld_act;
    logic [39:0] ld_up;
    logic        ld_apply;
    logic [39:0] mt_act;
    logic [39:0] wd_ld;
    logic [39:0] wd_mt;

    assign ld_wr    = st.d_wr & (st.d_addr == tam_pkg::A_ILR | st.d_addr == tam_pkg::A_PR);
    assign mt_wr    = st.d_wr & (st.d_addr == tam_pkg::A_MATCH | st.d_addr == tam_pkg::A_PMR);
    assign wd_ld[39:8] = (st.d_addr == tam_pkg::A_ILR) ? (hwdata & msk) : st.ilr;
    assign wd_ld[7:0]  = (st.d_addr == tam_pkg::A_PR) ? hwdata[7:0] : st.pr;
    assign wd_mt[39:8] = (st.d_addr == tam_pkg::A_MATCH) ? (hwdata & msk) : st.mt;
    assign wd_mt[7:0]  = (st.d_addr == tam_pkg::A_PMR) ? hwdata[7:0] : st.pmr;
    // Load deferral only applies while counting down
    assign ld_defer = st.mode[tam_pkg::B_ILD] & ~up;
    // A pending value lands when software turns the timer on
    assign start    = st.ctl[tam_pkg::C_RUN] & ~st.run_q;

    tam_update_stage #(.W(40)) u_load_stage (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .wr       (ld_wr),
        .wr_data  (wd_ld),
        .defer    (ld_defer),
        .timeout  (hit_to),
        .start    (start),
        .active   (ld_act),
        .upcoming (ld_up),
        .apply    (ld_apply)
    );

    tam_update_stage #(.W(40)) u_match_stage (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .wr       (mt_wr),
        .wr_data  (wd_mt),
        .defer    (st.mode[tam_pkg::B_MRSU]),
        .timeout  (hit_to),
        .start    (start),
        .active   (mt_act),
        .upcoming (),
        .apply    ()
    );

    // ------------------------------------------------------------
    // Count tick and time-out detection
    // ------------------------------------------------------------
    logic cnt_mode;
    logic mt_hit;

    assign cnt_mode = is_cap & ~st.mode[tam_pkg::B_CMR];
    // Edge-count ticks on pin events; others tick every cycle at 32-bit, via the prescaler at 16-bit
    assign tick   = active & (cnt_mode ? ccp_evt : (~w16 | st.ps == 8'h00));
    assign mt_hit = st.cnt == mt_act[39:8];
    assign hit_to = tick & (cnt_mode ? mt_hit
                  : (up ? st.cnt == ld_act[39:8] : st.cnt == tam_pkg::RST_WORD));

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] rd_val;

    always_comb begin
        rd_val = tam_pkg::RST_WORD;
        if (st.d_addr == tam_pkg::A_CFG) begin
            rd_val = {29'h0, st.cfg};
        end else if (st.d_addr == tam_pkg::A_MODE) begin
            rd_val = {20'h0, st.mode};
        end else if (st.d_addr == tam_pkg::A_CTL) begin
            rd_val = {26'h0, st.ctl};
        end else if (st.d_addr == tam_pkg::A_ILR) begin
            rd_val = st.ilr;
        end else if (st.d_addr == tam_pkg::A_MATCH) begin
            rd_val = st.mt;
        end else if (st.d_addr == tam_pkg::A_PR) begin
            rd_val = {24'h0, st.pr};
        end else if (st.d_addr == tam_pkg::A_PMR) begin
            rd_val = {24'h0, st.pmr};
        end else if (st.d_addr == tam_pkg::A_CNT) begin
            rd_val = (is_cap & st.mode[tam_pkg::B_CMR]) ? st.cap : st.cnt;
        end else if (st.d_addr == tam_pkg::A_FREE) begin
            rd_val = st.cnt;
        end else if (st.d_addr == tam_pkg::A_PS) begin
            rd_val = {24'h0, st.ps};
        end else if (st.d_addr == tam_pkg::A_DMAEV) begin
            rd_val = {29'h0, st.dmaev};
        end
    end

    // ------------------------------------------------------------
    // Next-state logic: bus, registers, counter, pin and events
    // ------------------------------------------------------------
    logic acc;

    assign acc = hsel & htrans[1] & hready & ~st.d_rd;

    always_comb begin
        next_st             = st;
        next_st.match_irq   = 1'b0;
        next_st.capture_irq = 1'b0;
        next_st.pwm_irq     = 1'b0;
        next_st.timeout     = 1'b0;
        next_st.dma_trig    = 1'b0;
        next_st.run_q       = st.ctl[tam_pkg::C_RUN];
        // Reads take one wait state so a read right after a write sees it
        next_st.d_wr = acc & hwrite;
        next_st.d_rd = acc & ~hwrite;
        if (acc) begin
            next_st.d_addr = haddr[7:0];
        end
        if (st.d_rd) begin
            next_st.rdata = rd_val;
        end
        if (st.d_wr) begin
            if (st.d_addr == tam_pkg::A_CFG) begin
                next_st.cfg = hwdata[2:0];
            end else if (st.d_addr == tam_pkg::A_MODE) begin
                next_st.mode = hwdata[11:0] & tam_pkg::MODE_MASK;
            end else if (st.d_addr == tam_pkg::A_CTL) begin
                next_st.ctl = hwdata[5:0] & tam_pkg::CTL_MASK;
            end else if (st.d_addr == tam_pkg::A_ILR) begin
                next_st.ilr = hwdata & msk;
            end else if (st.d_addr == tam_pkg::A_MATCH) begin
                next_st.mt = hwdata & msk;
            end else if (st.d_addr == tam_pkg::A_PR) begin
                next_st.pr = hwdata[7:0];
            end else if (st.d_addr == tam_pkg::A_PMR) begin
                next_st.pmr = hwdata[7:0];
            end else if (st.d_addr == tam_pkg::A_DMAEV) begin
                next_st.dmaev = hwdata[2:0] & tam_pkg::DMAEV_MASK;
            end
        end
        // Prescaler only runs for split 16-bit timers
        if (active & w16 & ~cnt_mode) begin
            next_st.ps = (st.ps == 8'h00) ? ld_act[7:0] : st.ps - 8'h01;
        end
        // Immediate or start-time load wins over counting
        if (ld_apply) begin
            next_st.cnt = up ? tam_pkg::RST_WORD : ld_act[39:8];
            next_st.ps  = ld_act[7:0];
        end else if (hit_to) begin
            next_st.timeout = 1'b1;
            next_st.cnt     = up ? tam_pkg::RST_WORD : ld_up[39:8];
            next_st.ps      = ld_up[7:0];
            if (cnt_mode) begin
                next_st.capture_irq = 1'b1;
                next_st.dma_trig    = st.dmaev[tam_pkg::D_CAP];
            end
            if ((is_tmr | is_pwm) & tmr == tam_pkg::TMR_ONESHOT) begin
                next_st.ctl[tam_pkg::C_RUN] = 1'b0;
            end
            if (is_pwm) begin
                next_st.pwm_out = st.mode[tam_pkg::B_PLO];
            end
        end else if (tick) begin
            next_st.cnt = (up ? st.cnt + 32'h1 : st.cnt - 32'h1) & msk;
        end
        // A switch to 16-bit width drops stale upper bits even while frozen
        next_st.cnt = next_st.cnt & msk;
        // Compare match: output edge in PWM, event in timer modes
        if (tick & mt_hit & is_pwm & ~hit_to) begin
            next_st.pwm_out = ~st.mode[tam_pkg::B_PLO];
        end
        if (tick & mt_hit & is_tmr & st.mode[tam_pkg::B_MIE]) begin
            next_st.match_irq = 1'b1;
            next_st.dma_trig  = st.dmaev[tam_pkg::D_MATCH];
        end
        // Edge-time capture latches the running count
        if (active & is_cap & st.mode[tam_pkg::B_CMR] & ccp_evt) begin
            next_st.cap         = st.cnt;
            next_st.capture_irq = 1'b1;
            next_st.dma_trig    = st.dmaev[tam_pkg::D_CAP];
        end
        // PWM output edges raise the PWM event and its DMA trigger
        if (is_pwm & st.mode[tam_pkg::B_PWMIE] & pwm_evt) begin
            next_st.pwm_irq  = 1'b1;
            next_st.dma_trig = st.ctl[tam_pkg::C_OTE] & st.dmaev[tam_pkg::D_CAP];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout   = ~st.d_rd;
    assign hresp       = 1'b0;
    assign hrdata      = st.rdata;
    assign ccp_out     = st.pwm_out;
    assign ccp_oe      = is_pwm;
    assign match_irq   = st.match_irq;
    assign capture_irq = st.capture_irq;
    assign pwm_irq     = st.pwm_irq;
    assign timeout_evt = st.timeout;
    assign dma_trigger = st.dma_trig;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_ld_now;
        ld_wr && !ld_defer;
    endsequence

    sequence s_ld_late;
        ld_wr && ld_defer && !start;
    endsequence

    a_mode_reserved: assert property ((st.mode & ~tam_pkg::MODE_MASK) == 12'h000)
        else $error("reserved mode bits set");
    a_load_next: assert property (s_ld_now |=> ld_apply ##1 (st.cnt == (up ? 32'h0 : $past(ld_act[39:8]))))
        else $error("immediate load not applied");
    a_load_defer: assert property (s_ld_late |=> !ld_apply)
        else $error("deferred load applied early");
    a_pwm_down: assert property (is_pwm && tick && !hit_to && !ld_apply |=> st.cnt == (($past(st.cnt) - 32'h1) & msk))
        else $error("pwm counter did not decrement");
    a_up_zero: assert property (ld_apply && up |=> st.cnt == 32'h0)
        else $error("up count did not start at zero");
    a_match_gate: assert property (match_irq |-> $past(st.mode[tam_pkg::B_MIE]) && $past(is_tmr))
        else $error("match event without enable");
    a_reload_level: assert property (is_pwm && hit_to && !ld_apply |=> ccp_out == $past(st.mode[tam_pkg::B_PLO]))
        else $error("pwm reload level wrong");
    a_pwm_irq_mode: assert property (pwm_irq |-> $past(is_pwm && st.mode[tam_pkg::B_PWMIE]))
        else $error("pwm event outside pwm mode");
    a_width_mask: assert property (w16 && $stable(st.cfg) |=> st.cnt[31:16] == 16'h0 || ld_apply)
        else $error("16-bit counter overflow");
endmodule

// ### bench/tam_pin_model.sv
// Bench model of the external source driving the capture pin
`timescale 1ns/1ps
module tam_pin_model (
    // Clock and enable
    input  wire logic hclk,
    input  wire logic run,
    // Pin level
    output logic      capture_compare_pin
);
    logic [1:0] div = 2'h0;
    initial capture_compare_pin = 1'b0;
    // Square wave of two-cycle halves; parked low when idle so no stray edges
    always @(posedge hclk) begin
        div <= div + 2'h1;
        capture_compare_pin <= run ? div[1] : 1'b0;
    end
endmodule

// ### bench/tb.sv
// Self-checking bench for the timer A mode-control block
`timescale 1ns/1ps
module tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run_pin = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, q_bus;
    logic [1:0]  htrans = 2'h0;
    logic        hreadyout, hresp, ccp_in, ccp_out, ccp_oe;
    logic        match_irq, capture_irq, pwm_irq, timeout_evt, dma_trigger;
    int          bad_count = 0, tests_run = 0, cycles = 0, t;
    int          n_to = 0, n_m = 0, n_c = 0, n_p = 0, n_d = 0, s_to, s_m, s_c, s_p, s_d;

    always #12.5 hclk = ~hclk;

    tam_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(q_bus),
        .debug_halt(1'b0), .ccp_in(ccp_in), .ccp_out(ccp_out), .ccp_oe(ccp_oe),
        .match_irq(match_irq), .capture_irq(capture_irq), .pwm_irq(pwm_irq),
        .timeout_evt(timeout_evt), .dma_trigger(dma_trigger));
    tam_pin_model pin (.hclk(hclk), .run(run_pin), .capture_compare_pin(ccp_in));

    // Event tallies and the hang limit; tallies are compared as differences
    always @(posedge hclk) begin
        cycles = cycles + 1;
        n_to += int'(timeout_evt === 1'b1);
        n_m += int'(match_irq === 1'b1);
        n_c += int'(capture_irq === 1'b1);
        n_p += int'(pwm_irq === 1'b1);
        n_d += int'(dma_trigger === 1'b1);
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One single AHB transfer; hready and read data are taken at the rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = q_bus;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // Cycles until the next time-out pulse
    task automatic wait_to(output int n);
        n = 0;
        do begin @(negedge hclk); n++; end while (timeout_evt !== 1'b1);
    endtask
    // Baseline waits two cycles so pulses of the old setting are not counted
    task automatic snap();
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        s_to = n_to; s_m = n_m; s_c = n_c; s_p = n_p; s_d = n_d;
        repeat (30) @(posedge hclk);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(tam_pkg::A_MODE, 32'h0);
        xfer(1'b1, tam_pkg::A_MODE, 32'hffffffff);
        rdc(tam_pkg::A_MODE, 32'h00000f3f);
        rdc(8'h80, 32'h0);
        xfer(1'b1, tam_pkg::A_CFG, 32'h0);
        xfer(1'b1, tam_pkg::A_ILR, 32'h5);
        xfer(1'b1, tam_pkg::A_MATCH, 32'h2);
        xfer(1'b1, tam_pkg::A_DMAEV, 32'h2);
        xfer(1'b1, tam_pkg::A_MODE, 32'h22);
        xfer(1'b1, tam_pkg::A_CTL, 32'h1);
        wait_to(t);
        wait_to(t);
        chk(t, 6);
        snap();
        chk({31'h0, n_m > s_m && n_d > s_d}, 32'h1);
        xfer(1'b1, tam_pkg::A_MODE, 32'h02);
        snap();
        chk({31'h0, n_m == s_m && n_d == s_d}, 32'h1);
        // Immediate load restarts the count; deferred load lets the old one finish
        wait_to(t);
        xfer(1'b1, tam_pkg::A_ILR, 32'd20);
        wait_to(t);
        chk({31'h0, t > 12}, 32'h1);
        xfer(1'b1, tam_pkg::A_MODE, 32'h102);
        xfer(1'b1, tam_pkg::A_ILR, 32'h5);
        wait_to(t);
        chk({31'h0, t > 12}, 32'h1);
        wait_to(t);
        chk(t, 6);
        xfer(1'b1, tam_pkg::A_MODE, 32'h0);
        snap();
        chk(n_to - s_to, 0);
        xfer(1'b1, tam_pkg::A_MODE, 32'h1);
        xfer(1'b1, tam_pkg::A_CTL, 32'h1);
        wait_to(t);
        rdc(tam_pkg::A_CTL, 32'h0);
        xfer(1'b1, tam_pkg::A_DMAEV, 32'h6);
        xfer(1'b1, tam_pkg::A_MODE, 32'ha0a);
        xfer(1'b1, tam_pkg::A_CTL, 32'h21);
        wait_to(t);
        chk({30'h0, ccp_oe, ccp_out}, 32'h3);
        snap();
        chk({30'h0, n_p > s_p, n_d > s_d}, 32'h3);
        xfer(1'b1, tam_pkg::A_MODE, 32'h7);
        run_pin <= 1'b1;
        snap();
        chk({31'h0, n_c > s_c}, 32'h1);
        // Edge-count up from zero; load stays immediate although deferral is set
        xfer(1'b1, tam_pkg::A_MODE, 32'h113);
        xfer(1'b1, tam_pkg::A_ILR, 32'h5);
        snap();
        chk({31'h0, n_c > s_c}, 32'h1);
        // Split 16-bit timer: values masked, prescaler halves the tick rate
        xfer(1'b1, tam_pkg::A_MODE, 32'h02);
        xfer(1'b1, tam_pkg::A_CFG, 32'h4);
        xfer(1'b1, tam_pkg::A_PR, 32'h1);
        xfer(1'b1, tam_pkg::A_ILR, 32'h00010005);
        rdc(tam_pkg::A_ILR, 32'h5);
        wait_to(t);
        wait_to(t);
        chk(t, 12);
        report_and_stop();
    end
endmodule
